//--- testbench/dc_brake_and_motor_set_select_tb_top.sv
// testbench for the brake and motor-set block
`timescale 1ns/1ps
module dc_brake_and_motor_set_select_tb_top;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] e;
	} row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rd;
	logic we = 1'b0, stb = 1'b0;
	logic bcmd = 1'b0, scmd = 1'b0, fcmd = 1'b0, rcmd = 1'b0;
	logic [4:0] term;
	logic fwd, rev, oon, bact, set2, ack;
	logic [7:0] blev;
	logic [15:0] ofreq;
	int error_cnt = 0, n_compared = 0, cyc_cnt = 0, k;
	row_t rows [6] = '{'{8'h04, 32'h32, 32'h32}, '{8'h04, 32'hFF, 32'h32},
		'{8'h08, 32'h64, 32'h64}, '{8'h08, 32'h65, 32'h64},
		'{8'h0C, 32'h807, 32'h807}, '{8'h40, 32'h5A, 32'h0}};
	dc_brake_and_motor_set_select #(.TENTH_CNT(4)) dut_u (
		.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(stb),
		.wb_stb_i(stb), .wb_ack_o(ack), .input_terminals(term),
		.forward_run_input(fwd), .reverse_run_input(rev),
		.output_on(oon), .brake_active(bact), .brake_level(blev),
		.out_freq(ofreq), .motor_set2_active(set2));
	term_ctrl_model model_u (.clk(clk), .brake_cmd(bcmd), .set_cmd(scmd),
		.fwd_cmd(fcmd), .rev_cmd(rcmd), .terminals(term),
		.fwd_run(fwd), .rev_run(rev));
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000)
		begin
			error_cnt++;
			give_verdict;
		end
	end
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic [31:0] d,
		input logic w);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		we <= w;
		stb <= 1'b1;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		rd = rdat;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// terminal 0 brakes, terminal 1 picks motor set, setpoint 16, force 75
	task automatic do_reset(input logic [31:0] d);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(8'h0C, 32'h807, 1'b1);
		bus(8'h10, 32'h10, 1'b1);
		bus(8'h08, 32'h4B, 1'b1);
		bus(8'h04, d, 1'b1);
	endtask
	initial
	begin
		do_reset(32'h0);
		foreach (rows[i])
		begin
			bus(rows[i].a, rows[i].w, 1'b1);
			bus(rows[i].a, 32'h0, 1'b0);
			cmp("reg", rows[i].e, rd);
		end
		do_reset(32'h0);
		@(posedge clk);
		fcmd <= 1'b1;
		while (ofreq !== 16'h10) @(negedge clk);
		@(posedge clk);
		scmd <= 1'b1;
		repeat (8) @(negedge clk);
		cmp("set2", 1'b0, set2);
		cmp("brake", 1'b0, bact);
		@(posedge clk);
		bcmd <= 1'b1;
		while (bact !== 1'b1) @(negedge clk);
		cmp("level", 32'h4B, blev);
		cmp("on", 1'b0, oon);
		@(posedge clk);
		bcmd <= 1'b0;
		while (ofreq !== 16'h10 || oon !== 1'b1) @(negedge clk);
		cmp("freq", 32'h10, ofreq);
		// same resume, run held by the reverse terminal
		@(posedge clk);
		fcmd <= 1'b0;
		rcmd <= 1'b1;
		bcmd <= 1'b1;
		while (bact !== 1'b1) @(negedge clk);
		cmp("rev on", 1'b0, oon);
		@(posedge clk);
		bcmd <= 1'b0;
		while (ofreq !== 16'h10 || oon !== 1'b1) @(negedge clk);
		cmp("rev freq", 32'h10, ofreq);
		@(posedge clk);
		rcmd <= 1'b0;
		scmd <= 1'b0;
		do_reset(32'h2);
		bus(8'h00, 32'h1, 1'b1);
		while (oon !== 1'b1) @(negedge clk);
		@(posedge clk);
		bcmd <= 1'b1;
		while (oon !== 1'b0) @(negedge clk);
		k = 0;
		while (bact !== 1'b1)
		begin
			@(negedge clk);
			k++;
		end
		cmp("coast", 1'b1, k >= 8 && k <= 10);
		@(posedge clk);
		bcmd <= 1'b0;
		repeat (10) @(negedge clk);
		cmp("off", 1'b0, oon);
		@(posedge clk);
		scmd <= 1'b1;
		repeat (6) @(negedge clk);
		cmp("set2", 1'b1, set2);
		@(posedge clk);
		scmd <= 1'b0;
		repeat (6) @(negedge clk);
		cmp("set2", 1'b0, set2);
		give_verdict;
	end
endmodule
bind dc_brake_and_motor_set_select dcb_chk chk_u (.clk(clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.output_on(output_on), .brake_active(brake_active),
	.brake_level(brake_level), .out_freq(out_freq),
	.motor_set2_active(motor_set2_active));

//--- testbench/dcb_chk_sva.sv
// port assertions for the brake and motor-set block
`timescale 1ns/1ps
module dcb_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic output_on,
	input wire logic brake_active,
	input wire logic [7:0] brake_level,
	input wire logic [15:0] out_freq,
	input wire logic motor_set2_active
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence running_s;
		output_on || out_freq != 16'h0000;
	endsequence
	sequence run_two_s;
		running_s ##1 running_s;
	endsequence
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	level_idle_a: assert property (!brake_active |-> brake_level == 8'h00)
		else $error("level when idle");
	level_max_a: assert property (brake_level <= 8'h64)
		else $error("level too high");
	brake_off_a: assert property (brake_active |-> !output_on)
		else $error("output on in brake");
	coast_first_a: assert property ($rose(brake_active) |-> !$past(output_on))
		else $error("no coast before brake");
	set_hold_a: assert property (run_two_s |-> $stable(motor_set2_active))
		else $error("set changed running");
	ramp_step_a: assert property (output_on && $past(output_on) &&
		out_freq > $past(out_freq) |-> out_freq == $past(out_freq) + 16'h0001)
		else $error("ramp step");
endmodule

//--- testbench/term_ctrl_model.sv
// controller model driving the input terminals and run inputs
`timescale 1ns/1ps
module term_ctrl_model (
	input wire logic clk,
	input wire logic brake_cmd,
	input wire logic set_cmd,
	input wire logic fwd_cmd,
	input wire logic rev_cmd,
	output logic [4:0] terminals,
	output logic fwd_run,
	output logic rev_run
);
	initial terminals = 5'h00;
	initial fwd_run = 1'b0;
	initial rev_run = 1'b0;
	always @(posedge clk)
	begin
		// brake only while commanded, never left on as a hold
		terminals[0] <= brake_cmd;
		terminals[1] <= set_cmd;
		fwd_run <= fwd_cmd;
		rev_run <= rev_cmd;
	end
endmodule

//--- verilog/dc_brake_and_motor_set_select.sv
// dc injection brake request and second motor set selection
`timescale 1ns/1ps
module dc_brake_and_motor_set_select #(
	parameter int TENTH_CNT = dcb_pkg::TENTH_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [dcb_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [dcb_pkg::DATA_W-1:0] wb_dat_i,
	output logic [dcb_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic [dcb_pkg::N_INPUTS-1:0] input_terminals,
	input wire logic forward_run_input,
	input wire logic reverse_run_input,
	output logic output_on,
	output logic brake_active,
	output logic [7:0] brake_level,
	output logic [15:0] out_freq,
	output logic motor_set2_active
);
	logic [dcb_pkg::N_INPUTS-1:0] term_s1_reg;
	logic [dcb_pkg::N_INPUTS-1:0] term_s2_reg;
	logic fwd_s1_reg;
	logic fwd_s2_reg;
	logic rev_s1_reg;
	logic rev_s2_reg;
	logic [1:0] ctrl_reg;
	logic [7:0] delay_reg;
	logic [7:0] force_reg;
	logic [39:0] func_reg;
	logic [15:0] freq_reg;
	logic [31:0] tick_reg;
	logic [7:0] tenths_reg;
	logic keypad_latch_reg;
	dcb_pkg::drive_state_t state_reg;
	dcb_pkg::drive_state_t state_next;
	logic brake_req;
	logic set_req;
	logic term_run;
	logic run_cmd;
	logic delay_done;
	logic bus_req;
	logic wr;

	// any terminal whose function matches the code
	function automatic logic func_hit(
		input logic [dcb_pkg::N_INPUTS-1:0] t,
		input logic [39:0] f,
		input logic [7:0] code
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < dcb_pkg::N_INPUTS; i++)
		begin
			if (t[i] && f[i*8 +: 8] == code)
			begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// clamp a byte to a ceiling
	function automatic logic [7:0] clamp8(
		input logic [7:0] v,
		input logic [7:0] lim
	);
		return (v > lim) ? lim : v;
	endfunction

	// terminals come from outside: two stage sync
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			term_s1_reg <= '0;
			term_s2_reg <= '0;
			fwd_s1_reg <= 1'b0;
			fwd_s2_reg <= 1'b0;
			rev_s1_reg <= 1'b0;
			rev_s2_reg <= 1'b0;
		end
		else
		begin
			term_s1_reg <= input_terminals;
			term_s2_reg <= term_s1_reg;
			fwd_s1_reg <= forward_run_input;
			fwd_s2_reg <= fwd_s1_reg;
			rev_s1_reg <= reverse_run_input;
			rev_s2_reg <= rev_s1_reg;
		end
	end

	assign brake_req = func_hit(term_s2_reg, func_reg,
		dcb_pkg::FUNC_BRAKE);
	assign set_req = func_hit(term_s2_reg, func_reg,
		dcb_pkg::FUNC_MOTOR2);
	assign term_run = fwd_s2_reg | rev_s2_reg;
	assign run_cmd = term_run | keypad_latch_reg;
	assign delay_done = (tenths_reg >= delay_reg);
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = bus_req & wb_we_i & wb_sel_i[0];

	// wishbone slave, one wait state, ack one cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= '0;
			if (bus_req && !wb_we_i)
			begin
				unique case (wb_adr_i)
					dcb_pkg::OFS_CTRL:
						wb_dat_o <= {30'h0, ctrl_reg};
					dcb_pkg::OFS_DELAY:
						wb_dat_o <= {24'h0, delay_reg};
					dcb_pkg::OFS_FORCE:
						wb_dat_o <= {24'h0, force_reg};
					dcb_pkg::OFS_FUNC:
						wb_dat_o <= func_reg[31:0];
					dcb_pkg::OFS_FREQ:
						wb_dat_o <= {8'h0, func_reg[39:32], freq_reg};
					dcb_pkg::OFS_STATUS:
						wb_dat_o <= {26'h0, keypad_latch_reg,
							motor_set2_active, state_reg};
					dcb_pkg::OFS_OUTFREQ:
						wb_dat_o <= {16'h0, out_freq};
					default:
						wb_dat_o <= '0;
				endcase
			end
		end
	end

	// setting registers; delay and force clamped to legal range
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			delay_reg <= dcb_pkg::DELAY_RST;
			force_reg <= dcb_pkg::FORCE_RST;
			func_reg <= {5{dcb_pkg::FUNC_RST}};
			freq_reg <= dcb_pkg::FREQ_RST;
		end
		else if (wr)
		begin
			unique case (wb_adr_i)
				dcb_pkg::OFS_DELAY:
					delay_reg <= clamp8(wb_dat_i[7:0],
						8'(dcb_pkg::DELAY_MAX_TENTHS));
				dcb_pkg::OFS_FORCE:
					force_reg <= clamp8(wb_dat_i[7:0],
						8'(dcb_pkg::FORCE_MAX_PCT));
				dcb_pkg::OFS_FUNC:
					func_reg[31:0] <= wb_dat_i;
				dcb_pkg::OFS_FREQ:
				begin
					freq_reg <= wb_dat_i[15:0];
					func_reg[39:32] <= wb_dat_i[23:16];
				end
				default:
					func_reg <= func_reg;
			endcase
		end
	end

	// keypad run/stop pulses; stop wins, brake release cancels keypad run
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg <= 2'b00;
			keypad_latch_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= 2'b00;
			if (wr && wb_adr_i == dcb_pkg::OFS_CTRL)
			begin
				ctrl_reg <= wb_dat_i[1:0];
			end
			if (ctrl_reg[dcb_pkg::CTRL_KEYPAD_STOP])
			begin
				keypad_latch_reg <= 1'b0;
			end
			else if ((state_reg == dcb_pkg::ST_BRAKE
				|| state_reg == dcb_pkg::ST_COAST)
				&& !brake_req && !term_run)
			begin
				keypad_latch_reg <= 1'b0;
			end
			else if (ctrl_reg[dcb_pkg::CTRL_KEYPAD_RUN])
			begin
				keypad_latch_reg <= 1'b1;
			end
		end
	end

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			dcb_pkg::ST_STOP:
				if (brake_req)
				begin
					state_next = dcb_pkg::ST_COAST;
				end
				else if (run_cmd)
				begin
					state_next = dcb_pkg::ST_RUN;
				end
			dcb_pkg::ST_RUN:
				if (brake_req)
				begin
					state_next = dcb_pkg::ST_COAST;
				end
				else if (!run_cmd)
				begin
					state_next = dcb_pkg::ST_STOP;
				end
			dcb_pkg::ST_COAST:
				if (!brake_req)
				begin
					state_next = term_run ? dcb_pkg::ST_RUN
						: dcb_pkg::ST_STOP;
				end
				else if (delay_done)
				begin
					state_next = dcb_pkg::ST_BRAKE;
				end
			dcb_pkg::ST_BRAKE:
				if (!brake_req)
				begin
					state_next = term_run ? dcb_pkg::ST_RUN
						: dcb_pkg::ST_STOP;
				end
			default:
				state_next = dcb_pkg::ST_STOP;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= dcb_pkg::ST_STOP;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// delay timer in tenths, counts only while coasting
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tick_reg <= '0;
			tenths_reg <= '0;
		end
		else if (state_reg != dcb_pkg::ST_COAST)
		begin
			tick_reg <= '0;
			tenths_reg <= '0;
		end
		else if (!delay_done)
		begin
			if (tick_reg >= 32'(TENTH_CNT - 1))
			begin
				tick_reg <= '0;
				tenths_reg <= tenths_reg + 8'h01;
			end
			else
			begin
				tick_reg <= tick_reg + 32'h1;
			end
		end
	end

	// output ramps to the setpoint, which stands for the pre-brake
	// frequency; a setpoint change while braking moves the target too
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_freq <= dcb_pkg::FREQ_RST;
			output_on <= 1'b0;
		end
		else
		begin
			output_on <= (state_next == dcb_pkg::ST_RUN);
			if (state_next != dcb_pkg::ST_RUN)
			begin
				out_freq <= dcb_pkg::FREQ_RST;
			end
			else if (out_freq < freq_reg)
			begin
				out_freq <= out_freq + dcb_pkg::RAMP_STEP;
			end
			else if (out_freq > freq_reg)
			begin
				out_freq <= out_freq - dcb_pkg::RAMP_STEP;
			end
		end
	end

	// braking outputs follow the state; force applied only while braking
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			brake_active <= 1'b0;
			brake_level <= 8'h00;
		end
		else
		begin
			brake_active <= (state_next == dcb_pkg::ST_BRAKE);
			brake_level <= (state_next == dcb_pkg::ST_BRAKE)
				? force_reg : 8'h00;
		end
	end

	// motor set latched whenever the output is off with zero frequency, in coast and brake too
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			motor_set2_active <= 1'b0;
		end
		else if (!output_on && out_freq == dcb_pkg::FREQ_RST)
		begin
			motor_set2_active <= set_req;
		end
	end
endmodule

//--- verilog/dcb_pkg.sv
// constants and types shared by the brake and motor-set logic
package dcb_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DELAY = 8'h04;
	localparam logic [7:0] OFS_FORCE = 8'h08;
	localparam logic [7:0] OFS_FUNC = 8'h0C;
	localparam logic [7:0] OFS_FREQ = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_OUTFREQ = 8'h18;
	// ctrl fields
	localparam int CTRL_KEYPAD_RUN = 0;
	localparam int CTRL_KEYPAD_STOP = 1;
	// brake delay in tenths of a second, 0.0 .. 5.0 s
	localparam int DELAY_MAX_TENTHS = 50;
	localparam int TENTH_MS = 100;
	localparam int TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
	localparam int FORCE_MAX_PCT = 100;
	// input terminal function codes
	localparam logic [7:0] FUNC_BRAKE = 8'h07;
	localparam logic [7:0] FUNC_MOTOR2 = 8'h08;
	localparam int N_INPUTS = 5;
	// reset values
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [7:0] FORCE_RST = 8'h00;
	localparam logic [7:0] FUNC_RST = 8'h00;
	localparam logic [15:0] FREQ_RST = 16'h0000;
	localparam logic [15:0] RAMP_STEP = 16'h0001;
	typedef enum logic [3:0] {
		ST_STOP = 4'b0001,
		ST_RUN = 4'b0010,
		ST_COAST = 4'b0100,
		ST_BRAKE = 4'b1000
	} drive_state_t;
endpackage
